// ===== logic/olm_lane_mapper.sv
// Output lane mapper: APB registers, word routing and LVDS serializer on the link clock.
`timescale 1ns/1ns

// What this block does
// - The frame clock runs once per conversion in 16- and 8-input modes and once per two in 32-input mode, where only single rate is allowed.
// - Switching single and double rate leaves the frame clock to conversion clock ratio unchanged.
// - Each lane stream sends its word LSB first, or MSB first when the bit order control is set.
// - In single rate mode pin n carries lane stream n for all 16 pins.
// - In double rate mode pins 1-4 carry streams 1,3,5,7, pins 9-12 carry 9,11,13,15, the rest are idle.
// - Each LVDS data buffer has its own power-down control bit.
// - The serial converter link is offered only in 16- and 32-input modes.
// - The serial converter link supports subclasses 0, 1 and 2.
// - The serializer input words go to the LVDS path, the link path or both, identical on each.
// - Writing 1 to the link enable control turns the link output on.
// - With the link enabled, writing 1 to the LVDS disable control turns LVDS off, 0 keeps both.
// - The link path runs on the system clock and presents one frame per conversion in 16- and 32-input modes alike.
// - In double rate mode a converter pair is packed into one lane stream at twice the bit rate.
// - The LVDS side provides a frame clock and a bit clock next to the data lanes.
module olm_lane_mapper
  import olm_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 linkClock,
  input  wire logic [11:0]          paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire olm_words_type        serialInWords,
  input  wire logic                 serialInValid,
  output olm_words_type             linkPathWord,
  output logic                      linkPathValid,
  output logic                      linkActive,
  output logic      [1:0]           linkSubclass,
  output logic      [NUM_LANES-1:0] lvdsBufPowerDown,
  output logic      [NUM_LANES-1:0] dataOut,
  output logic                      frameClockOut,
  output logic                      bitClockOut
);

  // -------------------------------------------------------------------------
  // Register file
  // -------------------------------------------------------------------------
  olm_cfg_type          cfg_r;
  logic [NUM_LANES-1:0] pwrDn_r;
  logic [15:0]          frameCount_r;
  logic                 apbWrite;
  logic                 apbSetup;
  logic                 addrOk;
  logic                 linkOn;
  logic                 lvdsOn;
  logic [31:0]          readValue;

  // Field order of the settings struct differs from the register layout, so
  // the reset image is assembled field by field.
  localparam olm_cfg_type CFG_RESET = olm_cfg_type'({
    CTRL_RESET[CTRL_MODE_LSB +: 2],
    CTRL_RESET[CTRL_DBL_BIT],
    CTRL_RESET[CTRL_MSB_BIT],
    CTRL_RESET[CTRL_SER_LSB +: 2],
    CTRL_RESET[CTRL_LINK_BIT],
    CTRL_RESET[CTRL_DIS_BIT],
    CTRL_RESET[CTRL_SUB_LSB +: 2]
  });

  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && pready && pwrite;
  assign addrOk   = (paddr == CTRL_ADDR) || (paddr == PWRDN_ADDR) || (paddr == STATUS_ADDR);
  assign linkOn   = cfg_r.serialLinkEnable && (cfg_r.inputMode != MODE_8);
  assign lvdsOn   = !(linkOn && cfg_r.lvdsOutputDisable);

  always_comb begin
    readValue = 32'h0000_0000;
    unique case (paddr)
      CTRL_ADDR: begin
        readValue[CTRL_MODE_LSB +: 2] = cfg_r.inputMode;
        readValue[CTRL_DBL_BIT]       = cfg_r.doubleRatePackingSelect;
        readValue[CTRL_MSB_BIT]       = cfg_r.msbFirst;
        readValue[CTRL_SER_LSB +: 2]  = cfg_r.serSel;
        readValue[CTRL_LINK_BIT]      = cfg_r.serialLinkEnable;
        readValue[CTRL_DIS_BIT]       = cfg_r.lvdsOutputDisable;
        readValue[CTRL_SUB_LSB +: 2]  = cfg_r.subclass;
      end
      PWRDN_ADDR: begin
        readValue[NUM_LANES-1:0] = pwrDn_r;
      end
      STATUS_ADDR: begin
        readValue = {14'h0000, lvdsOn, linkOn, frameCount_r};
      end
      default: begin
        readValue = 32'h0000_0000;
      end
    endcase
  end

  // The answer is prepared in the setup cycle so pready and prdata are flops;
  // every access therefore completes in its first access cycle.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= apbSetup;
      prdata  <= (apbSetup && !pwrite) ? readValue : 32'h0000_0000;
      pslverr <= apbSetup && !addrOk;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r   <= CFG_RESET;
      pwrDn_r <= PWRDN_RESET;
    end else if (apbWrite) begin
      if (paddr == CTRL_ADDR) begin
        // Unused mode code 3 is folded to 16-input mode.
        cfg_r.inputMode <= (pwdata[CTRL_MODE_LSB +: 2] == 2'h3) ? MODE_16
                                                                : pwdata[CTRL_MODE_LSB +: 2];
        cfg_r.doubleRatePackingSelect <= pwdata[CTRL_DBL_BIT];
        cfg_r.msbFirst                <= pwdata[CTRL_MSB_BIT];
        cfg_r.serSel                  <= pwdata[CTRL_SER_LSB +: 2];
        cfg_r.serialLinkEnable        <= pwdata[CTRL_LINK_BIT];
        cfg_r.lvdsOutputDisable       <= pwdata[CTRL_DIS_BIT];
        // Subclass 3 does not exist; such a write saturates to 2.
        cfg_r.subclass <= (pwdata[CTRL_SUB_LSB +: 2] > SUBCLASS_MAX) ? SUBCLASS_MAX
                                                                    : pwdata[CTRL_SUB_LSB +: 2];
      end else if (paddr == PWRDN_ADDR) begin
        pwrDn_r <= pwdata[NUM_LANES-1:0];
      end
    end
  end

  // Each settings write is announced to the link domain by a toggle; the
  // settings themselves stay put until the next write.
  logic cfgToggle_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfgToggle_r <= 1'b0;
    end else if (apbWrite && ((paddr == CTRL_ADDR) || (paddr == PWRDN_ADDR))) begin
      cfgToggle_r <= !cfgToggle_r;
    end
  end

  // -------------------------------------------------------------------------
  // Word capture and link path on the system clock
  // -------------------------------------------------------------------------
  olm_words_type wordHold_r;
  logic          wordToggle_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wordHold_r   <= '0;
      wordToggle_r <= 1'b0;
      frameCount_r <= 16'h0000;
    end else if (serialInValid) begin
      wordHold_r   <= serialInWords;
      wordToggle_r <= !wordToggle_r;
      frameCount_r <= frameCount_r + 16'h0001;
    end
  end

  // One link frame per conversion, the same words as the LVDS path.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      linkPathWord     <= '0;
      linkPathValid    <= 1'b0;
      linkActive       <= 1'b0;
      linkSubclass     <= 2'h0;
      lvdsBufPowerDown <= '0;
    end else begin
      linkPathWord     <= (linkOn && serialInValid) ? serialInWords : linkPathWord;
      linkPathValid    <= linkOn && serialInValid;
      linkActive       <= linkOn;
      linkSubclass     <= cfg_r.subclass;
      lvdsBufPowerDown <= pwrDn_r | {NUM_LANES{!lvdsOn}};
    end
  end

  // -------------------------------------------------------------------------
  // Crossing into the link clock domain
  // -------------------------------------------------------------------------
  // Settings and the word bank each cross under a toggle: only the toggle
  // passes a synchroniser, and the multi-bit value behind it is sampled once
  // the toggle has settled, so no half-updated word is ever taken.
  // Limitation: a value must stay stable for three link clocks after its
  // toggle flips, which holds at any sane conversion and write rate.
  olm_cfg_type          cfgLink_r;
  logic [NUM_LANES-1:0] pwrDnLink_r;
  logic                 lvdsLink_r;
  logic                 cfgTogMeta_r;
  logic                 cfgTogSync_r;
  logic                 cfgTogSeen_r;
  logic                 togMeta_r;
  logic                 togSync_r;
  logic                 togSeen_r;
  logic                 newCfg;

  // A settings write is seen once its toggle differs from the last one taken.
  assign newCfg = cfgTogSync_r != cfgTogSeen_r;

  // Two flops per toggle; the third copy only marks the edge.
  always_ff @(posedge linkClock or negedge rst_n) begin
    if (!rst_n) begin
      cfgTogMeta_r <= 1'b0;
      cfgTogSync_r <= 1'b0;
      cfgTogSeen_r <= 1'b0;
      togMeta_r    <= 1'b0;
      togSync_r    <= 1'b0;
      togSeen_r    <= 1'b0;
    end else begin
      cfgTogMeta_r <= cfgToggle_r;
      cfgTogSync_r <= cfgTogMeta_r;
      cfgTogSeen_r <= cfgTogSync_r;
      togMeta_r    <= wordToggle_r;
      togSync_r    <= togMeta_r;
      togSeen_r    <= togSync_r;
    end
  end

  // The reset image matches the register file: link off, so LVDS is on.
  always_ff @(posedge linkClock or negedge rst_n) begin
    if (!rst_n) begin
      cfgLink_r   <= CFG_RESET;
      pwrDnLink_r <= PWRDN_RESET;
      lvdsLink_r  <= 1'b1;
    end else if (newCfg) begin
      cfgLink_r   <= cfg_r;
      pwrDnLink_r <= pwrDn_r;
      lvdsLink_r  <= lvdsOn;
    end
  end

  // -------------------------------------------------------------------------
  // Serializer on the link clock
  // -------------------------------------------------------------------------
  olm_words_type bank_r;
  logic [5:0]    bitCnt_r;
  logic          serActive_r;
  logic          pairPhase_r;
  logic          newWord;
  logic          dblRate;
  logic [4:0]    serBits;
  logic [5:0]    frameLen;
  logic          secondWord;
  logic [4:0]    bitPos;
  logic [4:0]    bitSel;

  assign newWord = togSync_r != togSeen_r;
  // 32-input mode has no double rate; the select is ignored there.
  assign dblRate = cfgLink_r.doubleRatePackingSelect && (cfgLink_r.inputMode != MODE_32);

  always_comb begin
    unique case (cfgLink_r.serSel)
      2'h0: serBits = SER_BITS_0;
      2'h1: serBits = SER_BITS_1;
      2'h2: serBits = SER_BITS_2;
      2'h3: serBits = SER_BITS_3;
    endcase
  end

  // A packed pair doubles the bits per frame, so the bit rate doubles while
  // the frame still spans exactly one conversion.
  assign frameLen   = dblRate ? {serBits, 1'b0} : {1'b0, serBits};
  assign secondWord = dblRate && (bitCnt_r >= {1'b0, serBits});
  assign bitPos     = secondWord ? (bitCnt_r[4:0] - serBits) : bitCnt_r[4:0];
  assign bitSel     = cfgLink_r.msbFirst ? (serBits - 5'h01 - bitPos) : bitPos;

  always_ff @(posedge linkClock or negedge rst_n) begin
    if (!rst_n) begin
      bank_r      <= '0;
      bitCnt_r    <= 6'h00;
      serActive_r <= 1'b0;
      pairPhase_r <= 1'b0;
    end else if (newWord) begin
      bank_r      <= wordHold_r;
      bitCnt_r    <= 6'h00;
      serActive_r <= 1'b1;
      pairPhase_r <= (cfgLink_r.inputMode == MODE_32) ? !pairPhase_r : 1'b0;
    end else if (serActive_r) begin
      bitCnt_r    <= bitCnt_r + 6'h01;
      serActive_r <= bitCnt_r != (frameLen - 6'h01);
    end
  end

  // -------------------------------------------------------------------------
  // Pin mapping
  // -------------------------------------------------------------------------
  logic [NUM_LANES-1:0] pinBit;

  for (genvar p = 0; p < NUM_LANES; p++) begin : g_pin
    localparam int GRP  = p / 8;
    localparam int IDX  = p % 8;
    localparam int LANE = GRP * 8 + IDX * 2;
    logic [WORD_W-1:0] srcWord;
    logic              pinUsed;
    if (IDX < 4) begin : g_paired
      assign srcWord = dblRate ? (secondWord ? bank_r[LANE+1] : bank_r[LANE])
                               : bank_r[p];
      assign pinUsed = 1'b1;
    end else begin : g_single
      assign srcWord = bank_r[p];
      assign pinUsed = !dblRate;
    end
    assign pinBit[p] = serActive_r && pinUsed && srcWord[bitSel[3:0]];
  end

  always_ff @(posedge linkClock or negedge rst_n) begin
    if (!rst_n) begin
      dataOut <= '0;
    end else begin
      // Powered-down or disabled buffers are held low.
      dataOut <= lvdsLink_r ? (pinBit & ~pwrDnLink_r) : '0;
    end
  end

  // Both clocks stand low outside a frame, so the receiver sees no false edge.
  always_ff @(posedge linkClock or negedge rst_n) begin
    if (!rst_n) begin
      frameClockOut <= 1'b0;
      bitClockOut   <= 1'b0;
    end else begin
      if (!lvdsLink_r || !serActive_r) begin
        frameClockOut <= 1'b0;
        bitClockOut   <= 1'b0;
      end else begin
        // Each bit is framed by one bit-clock edge, so both edges carry data.
        bitClockOut <= !bitClockOut;
        if (cfgLink_r.inputMode == MODE_32) begin
          frameClockOut <= pairPhase_r;
        end else begin
          frameClockOut <= bitCnt_r < {1'b0, frameLen[5:1]};
        end
      end
    end
  end

endmodule : olm_lane_mapper

// ===== logic/olm_pkg.sv
// Package with register map, field layout and types of the output lane mapper.
package olm_pkg;

  localparam int NUM_LANES = 16;
  localparam int WORD_W    = 16;

  // -----------------------------------------------------------------------
  // Register map
  // -----------------------------------------------------------------------
  localparam logic [11:0] CTRL_ADDR   = 12'h000;
  localparam logic [11:0] PWRDN_ADDR  = 12'h004;
  localparam logic [11:0] STATUS_ADDR = 12'h008;

  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_DBL_BIT   = 2;
  localparam int CTRL_MSB_BIT   = 3;
  localparam int CTRL_SER_LSB   = 4;
  localparam int CTRL_LINK_BIT  = 6;
  localparam int CTRL_DIS_BIT   = 7;
  localparam int CTRL_SUB_LSB   = 8;

  localparam logic [31:0] CTRL_RESET  = 32'h0000_0030;
  localparam logic [15:0] PWRDN_RESET = 16'h0000;

  // -----------------------------------------------------------------------
  // Encodings
  // -----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_16 = 2'h0,
    MODE_32 = 2'h1,
    MODE_8  = 2'h2
  } olm_mode_type;

  // Serialization factor select: 10, 12, 14, 16 bits per word.
  localparam logic [4:0] SER_BITS_0 = 5'h0a;
  localparam logic [4:0] SER_BITS_1 = 5'h0c;
  localparam logic [4:0] SER_BITS_2 = 5'h0e;
  localparam logic [4:0] SER_BITS_3 = 5'h10;

  localparam logic [1:0] SUBCLASS_MAX = 2'h2;

  typedef struct packed {
    logic [1:0] inputMode;
    logic       doubleRatePackingSelect;
    logic       msbFirst;
    logic [1:0] serSel;
    logic       serialLinkEnable;
    logic       lvdsOutputDisable;
    logic [1:0] subclass;
  } olm_cfg_type;

  typedef logic [NUM_LANES-1:0][WORD_W-1:0] olm_words_type;

endpackage : olm_pkg

// ===== sim/olm_fpga_rx.sv
// Receiver model that captures every lane bit on each bit clock edge.
`timescale 1ns/1ns
module olm_fpga_rx
  import olm_pkg::*;
(
  input  wire logic                  linkClock,
  input  wire logic                  rxClear,
  input  wire logic [NUM_LANES-1:0]  dataOut,
  input  wire logic                  frameClockOut,
  input  wire logic                  bitClockOut,
  output logic [NUM_LANES-1:0][31:0] rxBits,
  output int                         rxCount,
  output int                         rxFrameHigh
);
  logic lastBitClock;
  // Sampling mid-cell on the falling link edge sees both bit clock edges as level changes.
  always @(negedge linkClock) begin
    lastBitClock <= bitClockOut;
    if (rxClear) begin
      rxBits <= '0;
      rxCount <= 0;
      rxFrameHigh <= 0;
    end else if (bitClockOut !== lastBitClock && rxCount < 32) begin
      for (int p = 0; p < NUM_LANES; p++) begin
        rxBits[p][rxCount] <= dataOut[p];
      end
      rxCount <= rxCount + 1;
      rxFrameHigh <= rxFrameHigh + (frameClockOut === 1'b1 ? 1 : 0);
    end
  end
endmodule : olm_fpga_rx

// ===== sim/olm_lane_mapper_props.sv
// Port-level assertions for the output lane mapper.
`timescale 1ns/1ns
module olm_lane_mapper_props
  import olm_pkg::*;
(
  input wire logic                 clock,
  input wire logic                 rst_n,
  input wire logic                 linkClock,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire olm_words_type        serialInWords,
  input wire logic                 serialInValid,
  input wire olm_words_type        linkPathWord,
  input wire logic                 linkPathValid,
  input wire logic                 linkActive,
  input wire logic [1:0]           linkSubclass,
  input wire logic [NUM_LANES-1:0] dataOut,
  input wire logic                 bitClockOut
);
  property p_ready_answer;
    @(posedge clock) disable iff (!rst_n) psel && !penable |=> pready;
  endproperty
  a_ready_answer: assert property (p_ready_answer) else $error("pready missing after setup");
  property p_ready_pulse;
    @(posedge clock) disable iff (!rst_n) pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  property p_read_idle;
    @(posedge clock) disable iff (!rst_n) !pready |-> prdata == 32'h0;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("prdata not zero outside access");
  property p_link_valid;
    @(posedge clock) disable iff (!rst_n) serialInValid && linkActive |=> linkPathValid;
  endproperty
  a_link_valid: assert property (p_link_valid) else $error("link word not passed on");
  property p_link_word;
    @(posedge clock) disable iff (!rst_n) linkPathValid |-> linkPathWord == $past(serialInWords);
  endproperty
  a_link_word: assert property (p_link_word) else $error("link word differs from input");
  property p_valid_cause;
    @(posedge clock) disable iff (!rst_n) linkPathValid |-> $past(serialInValid);
  endproperty
  a_valid_cause: assert property (p_valid_cause) else $error("link valid without input");
  property p_subclass;
    @(posedge clock) disable iff (!rst_n) linkSubclass != 2'h3;
  endproperty
  a_subclass: assert property (p_subclass) else $error("unsupported subclass shown");
  property p_bit_pulse;
    @(posedge linkClock) disable iff (!rst_n) bitClockOut |=> !bitClockOut;
  endproperty
  a_bit_pulse: assert property (p_bit_pulse) else $error("bit clock stuck high");
  property p_idle_zero;
    @(posedge linkClock) disable iff (!rst_n) !bitClockOut && !$past(bitClockOut) |-> dataOut == '0;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("data pins busy outside frame");
endmodule : olm_lane_mapper_props

bind olm_lane_mapper olm_lane_mapper_props u_props (
  .clock(clock), .rst_n(rst_n), .linkClock(linkClock), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .serialInWords(serialInWords),
  .serialInValid(serialInValid), .linkPathWord(linkPathWord), .linkPathValid(linkPathValid),
  .linkActive(linkActive), .linkSubclass(linkSubclass), .dataOut(dataOut),
  .bitClockOut(bitClockOut)
);

// ===== sim/testbench.sv
// Self-checking bench for the output lane mapper.
`timescale 1ns/1ns
module testbench;
  import olm_pkg::*;
  logic clock = 1'b0, linkClock = 1'b0, rst_n = 1'b0, rxClear = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, serialInValid = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdData;
  logic pready, pslverr, errSeen, linkPathValid, linkActive, frameClockOut, bitClockOut;
  logic [1:0] linkSubclass;
  logic [NUM_LANES-1:0] lvdsBufPowerDown, dataOut;
  logic [NUM_LANES-1:0][31:0] rxBits;
  olm_words_type serialInWords = '0, words, linkPathWord;
  int rxCount, rxFrameHigh, fail_count = 0, compares = 0, seq = 0;
  logic ph32 = 1'b0;
  logic [31:0] cfgCtrl [7] = '{32'h00, 32'h18, 32'h24, 32'h3c, 32'h05, 32'h05, 32'h02};

  always #10 clock = ~clock;
  initial begin
    #7;
    forever #16 linkClock = ~linkClock;
  end

  olm_lane_mapper u_olm_lane_mapper (.clock(clock), .rst_n(rst_n), .linkClock(linkClock),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .serialInWords(serialInWords),
    .serialInValid(serialInValid), .linkPathWord(linkPathWord), .linkPathValid(linkPathValid),
    .linkActive(linkActive), .linkSubclass(linkSubclass), .lvdsBufPowerDown(lvdsBufPowerDown),
    .dataOut(dataOut), .frameClockOut(frameClockOut), .bitClockOut(bitClockOut));
  olm_fpga_rx u_olm_fpga_rx (.linkClock(linkClock), .rxClear(rxClear), .dataOut(dataOut),
    .frameClockOut(frameClockOut), .bitClockOut(bitClockOut), .rxBits(rxBits),
    .rxCount(rxCount), .rxFrameHigh(rxFrameHigh));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdData = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input string what, input logic [11:0] a, input logic [31:0] e, input logic er);
    apb(1'b0, a, 32'h0);
    check(what, e, rdData);
    check("pslverr", {31'h0, er}, {31'h0, errSeen});
  endtask : rd

  // Configuration crosses to the link clock through synchronisers, so let it settle.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (6) @(posedge clock);
  endtask : wr

  task automatic send();
    rxClear <= 1'b1;
    repeat (3) @(posedge clock);
    seq++;
    for (int l = 0; l < NUM_LANES; l++) begin
      words[l] = 16'h9a37 + 16'(l) * 16'h0f1d + 16'(seq) * 16'h1357;
    end
    serialInWords <= words;
    serialInValid <= 1'b1;
    rxClear <= 1'b0;
    @(posedge clock);
    serialInValid <= 1'b0;
    repeat (80) @(posedge clock);
  endtask : send

  task automatic checkLanes(input logic [31:0] c, input logic [15:0] pd);
    int s, lane, fexp;
    logic dbl;
    logic [31:0] exp;
    s = 10 + 2 * c[5:4];
    dbl = c[2] && c[1:0] != 2'h1;
    for (int p = 0; p < NUM_LANES; p++) begin
      exp = '0;
      lane = dbl ? ((p % 8) < 4 ? (p / 8) * 8 + 2 * (p % 8) : -1) : p;
      for (int i = 0; i < s; i++) begin
        if (lane >= 0 && !pd[p]) begin
          exp[i] = words[lane][c[3] ? s - 1 - i : i];
          if (dbl) exp[s + i] = words[lane + 1][c[3] ? s - 1 - i : i];
        end
      end
      check($sformatf("pin %0d", p + 1), exp, rxBits[p]);
    end
    // 32-input frames alternate high and low, so the frame clock runs at half rate.
    ph32 = (c[1:0] == 2'h1) && !ph32;
    if (pd == 16'hffff) fexp = 0;
    else if (c[1:0] == 2'h1) fexp = ph32 ? s : 0;
    else fexp = dbl ? s : s / 2;
    check("frame clock", fexp, rxFrameHigh);
    check("bit count", pd == 16'hffff ? 0 : dbl ? 2 * s : s, rxCount);
  endtask : checkLanes

  task automatic checkLink();
    for (int l = 0; l < NUM_LANES; l++) begin
      check("link word", {16'h0, words[l]}, {16'h0, linkPathWord[l]});
    end
  endtask : checkLink

  task automatic end_of_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end

  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    rd("ctrl reset", CTRL_ADDR, CTRL_RESET, 1'b0);
    rd("pwrdn reset", PWRDN_ADDR, 32'h0, 1'b0);
    rd("unmapped", 12'h00c, 32'h0, 1'b1);
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      wr(CTRL_ADDR, cfgCtrl[i]);
      send();
      checkLanes(cfgCtrl[i], 16'h0);
    end
    $display("test lane mapping done");
    wr(CTRL_ADDR, 32'h70);
    check("linkActive", 1, {31'h0, linkActive});
    send();
    checkLink();
    checkLanes(32'h70, 16'h0);
    wr(CTRL_ADDR, 32'hf0);
    check("lvds off", 32'hffff, {16'h0, lvdsBufPowerDown});
    send();
    checkLink();
    checkLanes(32'hf0, 16'hffff);
    rd("status link", STATUS_ADDR, {14'h0, 2'h1, 16'(seq)}, 1'b0);
    wr(CTRL_ADDR, 32'h72);
    check("link in 8-input", 0, {31'h0, linkActive});
    wr(CTRL_ADDR, 32'h71);
    check("link in 32-input", 1, {31'h0, linkActive});
    $display("test link routing done");
    wr(CTRL_ADDR, 32'h33);
    rd("mode fold", CTRL_ADDR, 32'h30, 1'b0);
    wr(CTRL_ADDR, 32'h30);
    wr(PWRDN_ADDR, 32'h00f0);
    rd("pwrdn back", PWRDN_ADDR, 32'h00f0, 1'b0);
    check("pin power down", 32'h00f0, {16'h0, lvdsBufPowerDown});
    send();
    checkLanes(32'h30, 16'h00f0);
    for (int k = 0; k < 4; k++) begin
      wr(CTRL_ADDR, 32'h30 | (32'(k) << 8));
      check("subclass", k == 3 ? 2 : k, {30'h0, linkSubclass});
    end
    rd("status lvds", STATUS_ADDR, {14'h0, 2'h2, 16'(seq)}, 1'b0);
    $display("test power and subclass done");
    end_of_test();
  end
endmodule : testbench
